/* hw/tss_defs.svh */
// Constants of the TCP socket setup engine: offsets, codes, reset values.
// Included by the design modules and by the testbench; definitions only.
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH

// Socket count and fixed buffer layout
`define TSS_NUM_SOCKETS 8
`define TSS_TX_REGION 16'h8000
`define TSS_RX_REGION 16'hc000
`define TSS_BUF_MASK 16'h07ff
`define TSS_BUF_SHIFT 11

// Global register byte offsets
`define TSS_OFS_MODE 12'h000
`define TSS_OFS_GIMASK 12'h004
`define TSS_OFS_RETRY_TIME 12'h008
`define TSS_OFS_RETRY_CNT 12'h00c
`define TSS_OFS_HWADDR_LO 12'h010
`define TSS_OFS_HWADDR_HI 12'h014
`define TSS_OFS_GATEWAY 12'h018
`define TSS_OFS_SUBNET 12'h01c
`define TSS_OFS_STATION_IP 12'h020
`define TSS_OFS_GISTAT 12'h024

// Socket block: page 0x1, 32 bytes per socket, field offsets below
`define TSS_SOCK_PAGE 4'h1
`define TSS_SO_PROTO 5'h00
`define TSS_SO_PORT 5'h04
`define TSS_SO_CMD 5'h08
`define TSS_SO_STATUS 5'h0c
`define TSS_SO_FLAGS 5'h10
`define TSS_SO_MASK 5'h14
`define TSS_SO_PTR 5'h18
`define TSS_SO_PHYS 5'h1c

// Protocol mode, commands and status codes
`define TSS_PROTO_TCP 8'h01
`define TSS_CMD_OPEN 8'h01
`define TSS_CMD_LISTEN 8'h02
`define TSS_CMD_CONNECT 8'h04
`define TSS_CMD_CLOSE 8'h10
`define TSS_ST_CLOSED 8'h00
`define TSS_ST_INIT 8'h01
`define TSS_ST_LISTEN 8'h02
`define TSS_ST_SYN_SENT 8'h03
`define TSS_ST_SYN_RECV 8'h04
`define TSS_ST_CONNECTED 8'h05

// Event flag position and reset values
`define TSS_CON_BIT 0
`define TSS_MASK_RST 8'hff
`define TSS_GIMASK_RST 8'h00

`endif

/* hw/tss_pkg.sv */
// Types shared by the socket setup engine and its per-socket machine.
// Constants live in tss_defs.svh.
package tss_pkg;

	typedef enum logic [2:0] {
		ST_CLOSED, ST_INIT, ST_LISTEN, ST_SYN_SENT, ST_SYN_RECV, ST_CONNECTED
	} tss_state_e;

	// Command written by the host to one socket
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} tss_cmd_s;

	// Handshake events from the network side, one-cycle pulses
	typedef struct packed {
		logic syn;
		logic ack;
	} tss_peer_s;

endpackage : tss_pkg

/* hw/tss_socket.sv */
// Connection setup machine of one socket.
// Assumes one-cycle command pulses and synchronised peer event pulses.
`timescale 1ns/1ps
`include "tss_defs.svh"

module tss_socket
	import tss_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire tss_cmd_s cmd,
	input wire logic [7:0] proto_mode,
	input wire tss_peer_s peer,
	input wire logic flag_clr,
	output logic [7:0] status_code,
	output logic connected_flag,
	output logic syn_ack_tx,
	output logic connect_req_tx
);
	tss_state_e state;
	tss_state_e next_state;
	logic [7:0] next_status;
	logic is_open;
	logic is_listen;
	logic is_connect;
	logic is_close;

	// Command decode
	assign is_open = cmd.valid && cmd.code == `TSS_CMD_OPEN;
	assign is_listen = cmd.valid && cmd.code == `TSS_CMD_LISTEN;
	assign is_connect = cmd.valid && cmd.code == `TSS_CMD_CONNECT;
	assign is_close = cmd.valid && cmd.code == `TSS_CMD_CLOSE;

	// Next state; close wins over every other event
	always_comb
	begin
		next_state = state;
		case (state)
			ST_CLOSED:
				if (is_open && proto_mode == `TSS_PROTO_TCP)
					next_state = ST_INIT;
			ST_INIT:
				if (is_listen)
					next_state = ST_LISTEN;
				else if (is_connect)
					next_state = ST_SYN_SENT;
			ST_LISTEN:
				if (peer.syn)
					next_state = ST_SYN_RECV;
			ST_SYN_RECV, ST_SYN_SENT:
				if (peer.ack)
					next_state = ST_CONNECTED;
			ST_CONNECTED:
				next_state = ST_CONNECTED;
			default:
				next_state = ST_CLOSED;
		endcase
		if (is_close)
			next_state = ST_CLOSED;
	end

	// Status code seen by the host
	always_comb
	begin
		case (next_state)
			ST_INIT: next_status = `TSS_ST_INIT;
			ST_LISTEN: next_status = `TSS_ST_LISTEN;
			ST_SYN_SENT: next_status = `TSS_ST_SYN_SENT;
			ST_SYN_RECV: next_status = `TSS_ST_SYN_RECV;
			ST_CONNECTED: next_status = `TSS_ST_CONNECTED;
			default: next_status = `TSS_ST_CLOSED;
		endcase
	end

	// State, status, sticky flag and segment requests
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_CLOSED;
			status_code <= `TSS_ST_CLOSED;
			connected_flag <= 1'b0;
			syn_ack_tx <= 1'b0;
			connect_req_tx <= 1'b0;
		end
		else
		begin
			state <= next_state;
			status_code <= next_status;
			connected_flag <= (next_state == ST_CONNECTED &&
				state != ST_CONNECTED) || (connected_flag && !flag_clr);
			syn_ack_tx <= next_state == ST_SYN_RECV && state == ST_LISTEN;
			connect_req_tx <= next_state == ST_SYN_SENT && state == ST_INIT;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_open_to_init: assert property (state == ST_CLOSED && is_open &&
		proto_mode == `TSS_PROTO_TCP |=> status_code == `TSS_ST_INIT)
		else $error("open did not reach init");
	chk_closed_only_open: assert property (state == ST_CLOSED &&
		!is_open |=> status_code == `TSS_ST_CLOSED ##1 state != ST_LISTEN)
		else $error("closed socket left closed without open");
	chk_listen_entry: assert property (state == ST_INIT && is_listen
		|=> status_code == `TSS_ST_LISTEN && !connect_req_tx)
		else $error("listen not reached");
	chk_syn_answer: assert property (state == ST_LISTEN && peer.syn &&
		!is_close |=> syn_ack_tx && status_code == `TSS_ST_SYN_RECV)
		else $error("syn not answered");
	chk_conn_flag: assert property (state == ST_SYN_RECV && peer.ack &&
		!is_close |=> connected_flag && status_code == `TSS_ST_CONNECTED)
		else $error("connection not reported");
	chk_flag_sticky: assert property (connected_flag && !flag_clr
		|=> connected_flag)
		else $error("connected flag lost");
	chk_client_syn: assert property (state == ST_INIT && is_connect &&
		!is_listen |=> connect_req_tx ##1 !connect_req_tx)
		else $error("client connect request missing");
	chk_server_passive: assert property (state == ST_LISTEN
		|=> !connect_req_tx)
		else $error("server sent connect request");
	cov_server_conn: cover property (state == ST_LISTEN ##1
		state == ST_SYN_RECV ##[1:100] state == ST_CONNECTED);
	cov_client_conn: cover property (connect_req_tx ##[1:100]
		state == ST_CONNECTED);
	cov_flag_race: cover property (flag_clr && connected_flag &&
		next_state == ST_CONNECTED && state != ST_CONNECTED);

endmodule : tss_socket

/* hw/tss_engine.sv */
// TCP socket setup engine: APB register file, eight socket machines,
// buffer address map and the socket interrupt.
// Assumes an APB master on pclk and asynchronous peer event pins.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tss_defs.svh"

module tss_engine
	import tss_pkg::*;
#(
	parameter int NSOCK = `TSS_NUM_SOCKETS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NSOCK-1:0] peer_syn_in,
	input wire logic [NSOCK-1:0] peer_ack_in,
	output logic [NSOCK-1:0] syn_ack_tx,
	output logic [NSOCK-1:0] connect_req_tx,
	output logic irq,
	output logic interrupt_out_n
);
	// Global settings
	logic [7:0] global_mode;
	logic [7:0] global_interrupt_mask;
	logic [15:0] retry_interval;
	logic [7:0] retry_limit;
	logic [47:0] station_hw_address;
	logic [31:0] gateway_ip;
	logic [31:0] subnet_mask_setting;
	logic [31:0] station_ip;

	// Per-socket settings
	logic [7:0] socket_protocol_mode [NSOCK];
	logic [15:0] socket_source_port [NSOCK];
	logic [7:0] socket_event_mask [NSOCK];
	logic [15:0] socket_pointer [NSOCK];
	logic [7:0] socket_status_code [NSOCK];
	logic [NSOCK-1:0] connected_flag;
	logic [15:0] socket_tx_buffer_base [NSOCK];
	logic [15:0] socket_rx_buffer_base [NSOCK];
	logic [15:0] socket_tx_phys [NSOCK];
	logic [15:0] socket_rx_phys [NSOCK];

	// Peer event synchronisers
	logic [NSOCK-1:0] syn_s1;
	logic [NSOCK-1:0] syn_s2;
	logic [NSOCK-1:0] syn_s3;
	logic [NSOCK-1:0] ack_s1;
	logic [NSOCK-1:0] ack_s2;
	logic [NSOCK-1:0] ack_s3;
	logic [NSOCK-1:0] syn_pulse;
	logic [NSOCK-1:0] ack_pulse;

	// Bus decode
	logic wr_en;
	logic rd_setup;
	logic is_sock;
	logic [2:0] sidx;
	logic [4:0] sfld;
	logic hit_global;
	logic hit;
	logic [31:0] next_prdata;
	logic [NSOCK-1:0] sock_pend;
	logic next_irq;

	// Buffer start plus masked pointer offset, wrapping within 2 KB
	function automatic logic [15:0] buf_addr(input logic [15:0] region,
		input logic [2:0] n, input logic [15:0] ptr);
		logic [15:0] base;
		base = region + {2'b00, n, 11'h000};
		return base | (ptr & `TSS_BUF_MASK);
	endfunction : buf_addr

	// Zero-wait slave: answers in the access phase of every transfer
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign is_sock = paddr[11:8] == `TSS_SOCK_PAGE && paddr[1:0] == 2'b00;
	assign sidx = paddr[7:5];
	assign sfld = paddr[4:0];
	assign hit_global = paddr <= `TSS_OFS_GISTAT && paddr[1:0] == 2'b00;
	assign hit = hit_global || (is_sock && 32'(sidx) < NSOCK);
	assign pslverr = psel && penable && !hit;

	// Interrupt: socket flag, socket mask and global socket mask
	assign next_irq = |(sock_pend & global_interrupt_mask);
	assign interrupt_out_n = !irq;

	// Two flip-flops, then an edge detect on the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			syn_s1 <= '0;
			syn_s2 <= '0;
			syn_s3 <= '0;
			ack_s1 <= '0;
			ack_s2 <= '0;
			ack_s3 <= '0;
		end
		else
		begin
			syn_s1 <= peer_syn_in;
			syn_s2 <= syn_s1;
			syn_s3 <= syn_s2;
			ack_s1 <= peer_ack_in;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
		end
	end
	assign syn_pulse = syn_s2 & ~syn_s3;
	assign ack_pulse = ack_s2 & ~ack_s3;

	// Eight independent sockets with fixed buffer bases
	for (genvar i = 0; i < NSOCK; i++)
	begin : g_sock
		tss_cmd_s cmd;
		tss_peer_s peer;
		logic flag_clr;
		logic sel;

		assign sel = wr_en && is_sock && 32'(sidx) == i;
		assign cmd.valid = sel && sfld == `TSS_SO_CMD;
		assign cmd.code = pwdata[7:0];
		assign flag_clr = sel && sfld == `TSS_SO_FLAGS &&
			pwdata[`TSS_CON_BIT];
		assign peer.syn = syn_pulse[i];
		assign peer.ack = ack_pulse[i];
		assign socket_tx_buffer_base[i] =
			buf_addr(`TSS_TX_REGION, 3'(i), 16'h0000);
		assign socket_rx_buffer_base[i] =
			buf_addr(`TSS_RX_REGION, 3'(i), 16'h0000);
		assign socket_tx_phys[i] =
			buf_addr(`TSS_TX_REGION, 3'(i), socket_pointer[i]);
		assign socket_rx_phys[i] =
			buf_addr(`TSS_RX_REGION, 3'(i), socket_pointer[i]);
		assign sock_pend[i] = connected_flag[i] &&
			socket_event_mask[i][`TSS_CON_BIT];

		tss_socket u_sock (
			.pclk(pclk),
			.presetn(presetn),
			.cmd(cmd),
			.proto_mode(socket_protocol_mode[i]),
			.peer(peer),
			.flag_clr(flag_clr),
			.status_code(socket_status_code[i]),
			.connected_flag(connected_flag[i]),
			.syn_ack_tx(syn_ack_tx[i]),
			.connect_req_tx(connect_req_tx[i])
		);
	end

	// Global register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			global_mode <= 8'h00;
			global_interrupt_mask <= `TSS_GIMASK_RST;
			retry_interval <= 16'h0000;
			retry_limit <= 8'h00;
			station_hw_address <= 48'h000000000000;
			gateway_ip <= 32'h00000000;
			subnet_mask_setting <= 32'h00000000;
			station_ip <= 32'h00000000;
		end
		else if (wr_en && hit_global)
		begin
			case (paddr)
				`TSS_OFS_MODE: global_mode <= pwdata[7:0];
				`TSS_OFS_GIMASK: global_interrupt_mask <= pwdata[7:0];
				`TSS_OFS_RETRY_TIME: retry_interval <= pwdata[15:0];
				`TSS_OFS_RETRY_CNT: retry_limit <= pwdata[7:0];
				`TSS_OFS_HWADDR_LO: station_hw_address[31:0] <= pwdata;
				`TSS_OFS_HWADDR_HI:
					station_hw_address[47:32] <= pwdata[15:0];
				`TSS_OFS_GATEWAY: gateway_ip <= pwdata;
				`TSS_OFS_SUBNET: subnet_mask_setting <= pwdata;
				`TSS_OFS_STATION_IP: station_ip <= pwdata;
				default: global_mode <= global_mode;
			endcase
		end
	end

	// Socket register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NSOCK; i++)
			begin
				socket_protocol_mode[i] <= 8'h00;
				socket_source_port[i] <= 16'h0000;
				socket_event_mask[i] <= `TSS_MASK_RST;
				socket_pointer[i] <= 16'h0000;
			end
		end
		else if (wr_en && is_sock && 32'(sidx) < NSOCK)
		begin
			case (sfld)
				`TSS_SO_PROTO: socket_protocol_mode[sidx] <= pwdata[7:0];
				`TSS_SO_PORT: socket_source_port[sidx] <= pwdata[15:0];
				`TSS_SO_MASK: socket_event_mask[sidx] <= pwdata[7:0];
				`TSS_SO_PTR: socket_pointer[sidx] <= pwdata[15:0];
				default: socket_pointer[sidx] <= socket_pointer[sidx];
			endcase
		end
	end

	// Read multiplexer; unmapped words read as zero
	always_comb
	begin
		next_prdata = 32'h00000000;
		if (is_sock && 32'(sidx) < NSOCK)
		begin
			case (sfld)
				`TSS_SO_PROTO: next_prdata[7:0] = socket_protocol_mode[sidx];
				`TSS_SO_PORT: next_prdata[15:0] = socket_source_port[sidx];
				`TSS_SO_STATUS: next_prdata[7:0] = socket_status_code[sidx];
				`TSS_SO_FLAGS:
					next_prdata[`TSS_CON_BIT] = connected_flag[sidx];
				`TSS_SO_MASK: next_prdata[7:0] = socket_event_mask[sidx];
				`TSS_SO_PTR: next_prdata = {socket_tx_buffer_base[sidx],
					socket_pointer[sidx]};
				`TSS_SO_PHYS: next_prdata = {socket_rx_phys[sidx],
					socket_tx_phys[sidx]};
				default: next_prdata = 32'h00000000;
			endcase
		end
		else if (hit_global)
		begin
			case (paddr)
				`TSS_OFS_MODE: next_prdata[7:0] = global_mode;
				`TSS_OFS_GIMASK: next_prdata[7:0] = global_interrupt_mask;
				`TSS_OFS_RETRY_TIME: next_prdata[15:0] = retry_interval;
				`TSS_OFS_RETRY_CNT: next_prdata[7:0] = retry_limit;
				`TSS_OFS_HWADDR_LO: next_prdata = station_hw_address[31:0];
				`TSS_OFS_HWADDR_HI:
					next_prdata[15:0] = station_hw_address[47:32];
				`TSS_OFS_GATEWAY: next_prdata = gateway_ip;
				`TSS_OFS_SUBNET: next_prdata = subnet_mask_setting;
				`TSS_OFS_STATION_IP: next_prdata = station_ip;
				`TSS_OFS_GISTAT: next_prdata[NSOCK-1:0] = sock_pend;
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	// Read data captured in the setup phase; interrupt level registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			irq <= 1'b0;
		end
		else
		begin
			if (rd_setup)
				prdata <= next_prdata;
			irq <= next_irq;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_irq_level: assert property ((|(sock_pend & global_interrupt_mask))
		|=> !interrupt_out_n ##0 irq)
		else $error("interrupt not driven low");
	chk_irq_quiet: assert property (sock_pend == '0 |=> interrupt_out_n)
		else $error("interrupt without pending flag");
	chk_tx_map: assert property (socket_tx_buffer_base[NSOCK-1] ==
		16'h8000 + 16'((NSOCK - 1) * 2048))
		else $error("tx base wrong");
	chk_rx_map: assert property (socket_rx_buffer_base[NSOCK-1] ==
		16'hc000 + 16'((NSOCK - 1) * 2048))
		else $error("rx base wrong");
	chk_buf_wrap: assert property (socket_tx_phys[0] ==
		(16'h8000 | (socket_pointer[0] & 16'h07ff)))
		else $error("tx offset not wrapped");
	cov_irq: cover property (!interrupt_out_n ##1 interrupt_out_n);
	cov_bad_addr: cover property (pslverr);

endmodule : tss_engine

/* test/tss_peer_model.sv */
// Network peer model: answers SYN/ACK or SYN with a one-cycle ACK pulse.
// Assumes one-cycle request pulses from the engine on pclk.
`timescale 1ns/1ps

module tss_peer_model
	import tss_pkg::*;
#(
	parameter int NSOCK = 8,
	parameter int SLOW = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NSOCK-1:0] syn_req,
	input wire logic [NSOCK-1:0] syn_ack_tx,
	input wire logic [NSOCK-1:0] connect_req_tx,
	output logic [NSOCK-1:0] peer_syn_in,
	output logic [NSOCK-1:0] peer_ack_in
);
	logic [4:0] cnt [NSOCK];

	// Even sockets get a prompt answer, odd ones wait SLOW cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			peer_syn_in <= '0;
			peer_ack_in <= '0;
			for (int i = 0; i < NSOCK; i++)
				cnt[i] <= '0;
		end
		else
		begin
			peer_syn_in <= syn_req;
			for (int i = 0; i < NSOCK; i++)
			begin
				peer_ack_in[i] <= (cnt[i] == 5'h1);
				if (syn_ack_tx[i] | connect_req_tx[i])
					cnt[i] <= i[0] ? 5'(SLOW) : 5'h1;
				else if (cnt[i] != 5'h0)
					cnt[i] <= cnt[i] - 5'h1;
			end
		end
	end
endmodule : tss_peer_model

/* test/tb_tss_engine.sv */
// Testbench of the socket setup engine: APB master tasks and checks.
// Assumes the package, the design and the peer model are compiled first.
`timescale 1ns/1ps
`include "tss_defs.svh"

module tb_tss_engine
	import tss_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic irq, interrupt_out_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [7:0] syn_req, peer_syn_in, peer_ack_in, syn_ack_tx;
	logic [7:0] connect_req_tx, seen_req, seen_sa;
	logic [15:0] p, tx, rx;
	int mismatches, total_checks;
	logic [11:0] gofs [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
		12'h014, 12'h018, 12'h01c, 12'h020};

	tss_engine i_tss_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.peer_syn_in(peer_syn_in), .peer_ack_in(peer_ack_in),
		.syn_ack_tx(syn_ack_tx), .connect_req_tx(connect_req_tx),
		.irq(irq), .interrupt_out_n(interrupt_out_n));

	tss_peer_model i_tss_peer_model (.pclk(pclk), .presetn(presetn),
		.syn_req(syn_req), .syn_ack_tx(syn_ack_tx),
		.connect_req_tx(connect_req_tx), .peer_syn_in(peer_syn_in),
		.peer_ack_in(peer_ack_in));

	// Clock at 100 MHz
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Sticky record of outgoing handshake pulses, cleared while in reset
	always @(posedge pclk)
	begin
		if (!presetn)
		begin
			seen_req <= '0;
			seen_sa <= '0;
		end
		else
		begin
			seen_req <= seen_req | connect_req_tx;
			seen_sa <= seen_sa | syn_ack_tx;
		end
	end

	function automatic logic [11:0] so(input int i, input logic [4:0] f);
		return {`TSS_SOCK_PAGE, i[2:0], f};
	endfunction : so

	function automatic logic [31:0] b(input logic x);
		return {31'h0, x};
	endfunction : b

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	// One APB transfer; holds the request until pready is seen high, for at most 50 cycles
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", 32'h1, b(pready));
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input string what, input logic [11:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, exp, rv);
	endtask : rchk

	task automatic cmd(input int i, input logic [7:0] c);
		wr(so(i, `TSS_SO_CMD), {24'h0, c});
	endtask : cmd

	// Mode TCP, then source port, then open
	task automatic open(input int i);
		wr(so(i, `TSS_SO_PROTO), 32'h1);
		wr(so(i, `TSS_SO_PORT), 32'h1388 + 32'(i));
		cmd(i, `TSS_CMD_OPEN);
	endtask : open

	// Hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		mismatches++;
		finish_test;
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		syn_req = '0;
		mismatches = 0;
		total_checks = 0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		check("intr_n", 32'h1, b(interrupt_out_n));
		// Reset state and the fixed buffer map of every socket
		for (int i = 0; i < 8; i++)
		begin
			p = 16'h1ff0 + 16'(i * 3);
			tx = 16'h8000 + 16'(i * 16'h0800);
			rx = 16'hc000 + 16'(i * 16'h0800);
			rchk("status", so(i, `TSS_SO_STATUS), 32'h0);
			rchk("mask", so(i, `TSS_SO_MASK), 32'hff);
			wr(so(i, `TSS_SO_PTR), {16'h0, p});
			rchk("ptr", so(i, `TSS_SO_PTR), {tx, p});
			rchk("phys", so(i, `TSS_SO_PHYS), {rx + (p & 16'h07ff),
				tx + (p & 16'h07ff)});
		end
		$display("test buffer_map done");
		// Global settings written first, then read back
		for (int k = 0; k < 9; k++)
			wr(gofs[k], 32'(k * 8'h11 + 8'h21));
		for (int k = 0; k < 9; k++)
			rchk("global", gofs[k], 32'(k * 8'h11 + 8'h21));
		rchk("unmapped", 12'h028, 32'h0);
		check("slverr", 32'h1, b(er));
		wr(`TSS_OFS_GIMASK, 32'h0a);
		$display("test globals done");
		// Closed socket ignores listen and a non-TCP open
		cmd(0, `TSS_CMD_LISTEN);
		rchk("status0", so(0, `TSS_SO_STATUS), 32'h0);
		cmd(0, `TSS_CMD_OPEN);
		rchk("status0", so(0, `TSS_SO_STATUS), 32'h0);
		// Server on socket 1 with a slow peer
		open(1);
		rchk("status1", so(1, `TSS_SO_STATUS), 32'(`TSS_ST_INIT));
		cmd(1, `TSS_CMD_LISTEN);
		rchk("status1", so(1, `TSS_SO_STATUS), 32'(`TSS_ST_LISTEN));
		syn_req[1] <= 1'b1;
		for (int n = 0; n < 100 && seen_sa[1] !== 1'b1; n++)
			@(posedge pclk);
		check("syn_ack1", 32'h1, b(seen_sa[1]));
		rchk("status1", so(1, `TSS_SO_STATUS), 32'(`TSS_ST_SYN_RECV));
		for (int n = 0; n < 100 && irq !== 1'b1; n++)
			@(posedge pclk);
		check("intr_n", 32'h0, b(interrupt_out_n));
		rchk("status1", so(1, `TSS_SO_STATUS), 32'(`TSS_ST_CONNECTED));
		wr(so(1, `TSS_SO_FLAGS), 32'h0);
		rchk("flags1", so(1, `TSS_SO_FLAGS), 32'h1);
		check("server_req", 32'h0, b(seen_req[1]));
		wr(so(1, `TSS_SO_MASK), 32'h0);
		rchk("mask1", so(1, `TSS_SO_MASK), 32'h0);
		check("irq_masked", 32'h0, b(irq));
		wr(so(1, `TSS_SO_MASK), 32'h1);
		wr(`TSS_OFS_GIMASK, 32'h08);
		rchk("gimask", `TSS_OFS_GIMASK, 32'h08);
		check("irq_gmask", 32'h0, b(irq));
		wr(`TSS_OFS_GIMASK, 32'h0a);
		rchk("gimask", `TSS_OFS_GIMASK, 32'h0a);
		check("irq_on", 32'h1, b(irq));
		rchk("pending", `TSS_OFS_GISTAT, 32'h2);
		wr(so(1, `TSS_SO_FLAGS), 32'h1);
		rchk("flags1", so(1, `TSS_SO_FLAGS), 32'h0);
		check("irq_clr", 32'h0, b(irq));
		$display("test server done");
		// Client on socket 3, alongside the live server
		open(3);
		cmd(3, `TSS_CMD_CONNECT);
		rchk("status3", so(3, `TSS_SO_STATUS), 32'(`TSS_ST_SYN_SENT));
		check("client_req", 32'h1, b(seen_req[3]));
		check("client_sa", 32'h0, b(seen_sa[3]));
		for (int n = 0; n < 100 && irq !== 1'b1; n++)
			@(posedge pclk);
		rchk("status3", so(3, `TSS_SO_STATUS), 32'(`TSS_ST_CONNECTED));
		rchk("status1", so(1, `TSS_SO_STATUS), 32'(`TSS_ST_CONNECTED));
		cmd(3, `TSS_CMD_LISTEN);
		rchk("status3", so(3, `TSS_SO_STATUS), 32'(`TSS_ST_CONNECTED));
		$display("test client done");
		// Close, refused listen, then the open sequence again
		cmd(1, `TSS_CMD_CLOSE);
		rchk("status1", so(1, `TSS_SO_STATUS), 32'h0);
		cmd(1, `TSS_CMD_LISTEN);
		rchk("status1", so(1, `TSS_SO_STATUS), 32'h0);
		open(1);
		rchk("status1", so(1, `TSS_SO_STATUS), 32'(`TSS_ST_INIT));
		$display("test reopen done");
		finish_test;
	end
endmodule : tb_tss_engine
